/* core/pcpd_hold.sv */
`timescale 1ns/1ps
// Purpose: Per-pin hold latch with freeze control
// Assumes: Sampled, synchronous data
// Notes: Keeps last value while freeze is high
module pcpd_hold #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Control
  input  wire logic         freeze,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] val;
  } pcpd_hold_s;
  pcpd_hold_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!freeze) begin
      s_d.val = d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.val;
endmodule // pcpd_hold

/* core/pcpd_pkg.sv */
// Purpose: Constants for the pin-controlled power-down block
// Assumes: mclk at 100 MHz
// Notes: Behaviour list below
// Behaviour
// - Two pins, either may request sleep
// - Sleep function fixed by configuration parameter
// - High level on sleep pin requests sleep
// - Outputs and logic state held while asleep
// - Outputs in high-impedance stay high-impedance
// - Inputs ignored while asleep except request and any sleep pin not used for sleep
// - Pin hold latches keep last level asleep
// - Sleep pin input path hidden from logic
// - Sleep pin macrocell output resources stay usable
// - Wake within one microsecond after pin low
package pcpd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WAKE_MAX_US   = 1;
  // Longest time rounds down
  localparam int unsigned WAKE_CYCLES   = (WAKE_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_USED     = WAKE_CYCLES / 2;
  localparam int unsigned CNT_W         = 8;
  localparam logic [7:0]  WAKE_LOAD     = 8'(WAKE_USED);
endpackage

/* core/pcpd_top.sv */
`timescale 1ns/1ps
// Purpose: Pin-controlled power-down freeze of a logic core's pins
// Assumes: User core runs on mclk; pins asynchronous to it
// Notes: Core outputs and enables are frozen while asleep
module pcpd_top #(
  parameter int unsigned IN_W   = 8,
  parameter int unsigned OUT_W  = 8,
  parameter bit          USE_PIN_A = 1'b1,
  parameter bit          USE_PIN_B = 1'b0
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Sleep request pins, with their normal input use
  input  wire logic             sleep_request_pin_a,
  input  wire logic             sleep_request_pin_b,
  // Device input pins
  input  wire logic [IN_W-1:0]  pin_in,
  // Core side: values seen by the logic array
  output logic      [IN_W-1:0]  core_in,
  output logic                  core_pin_a_in,
  output logic                  core_pin_b_in,
  output logic                  core_clk_en,
  // Core side: what the array wants to drive
  input  wire logic [OUT_W-1:0] core_out,
  input  wire logic [OUT_W-1:0] core_oe,
  // Device output pins
  output logic      [OUT_W-1:0] pin_out,
  output logic      [OUT_W-1:0] pin_oe,
  // Status
  output logic                  asleep
);
  typedef struct packed {
    logic [1:0]            a_sync;
    logic [1:0]            b_sync;
    logic [IN_W-1:0]       in_s1;
    logic [IN_W-1:0]       in_s2;
    logic                  sleep;
    logic                  waking;
    logic [pcpd_pkg::CNT_W-1:0] cnt;
    logic [OUT_W-1:0]      out;
    logic [OUT_W-1:0]      oe;
    logic                  pa;
    logic                  pb;
    logic                  clk_en;
  } pcpd_top_s;
  pcpd_top_s s_q, s_d;

  logic req;
  logic frozen;
  logic [IN_W-1:0] held_in;

  // Sleep when any enabled pin is high
  assign req = (USE_PIN_A && s_q.a_sync[1]) || (USE_PIN_B && s_q.b_sync[1]);
  assign frozen = s_q.sleep || s_q.waking;

  // Input pins keep last level while asleep
  pcpd_hold #(.W(IN_W)) u_hold (
    .mclk   (mclk),
    .rst    (rst),
    .freeze (frozen),
    .d      (s_q.in_s2),
    .q      (held_in)
  );

  always_comb begin
    s_d        = s_q;
    s_d.a_sync = {s_q.a_sync[0], sleep_request_pin_a};
    s_d.b_sync = {s_q.b_sync[0], sleep_request_pin_b};
    s_d.in_s1  = pin_in;
    s_d.in_s2  = s_q.in_s1;
    if (req) begin
      s_d.sleep  = 1'b1;
      s_d.waking = 1'b0;
    end else if (s_q.sleep) begin
      s_d.sleep  = 1'b0;
      s_d.waking = 1'b1;
      s_d.cnt    = pcpd_pkg::WAKE_LOAD;
    end else if (s_q.waking) begin
      if (s_q.cnt == '0) begin
        s_d.waking = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
    // Freeze output data and enables, high-impedance kept too
    if (!frozen && !req) begin
      s_d.out = core_out;
      s_d.oe  = core_oe;
    end
    // Pin input path is hidden when used as sleep control
    s_d.pa     = USE_PIN_A ? 1'b0 : s_q.a_sync[1];
    s_d.pb     = USE_PIN_B ? 1'b0 : s_q.b_sync[1];
    // Array clock stops so core registers keep their state
    s_d.clk_en = !(frozen || req);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Output pin resources stay usable regardless of sleep pin role
  assign pin_out       = s_q.out;
  assign pin_oe        = s_q.oe;
  assign core_in       = held_in;
  assign core_pin_a_in = s_q.pa;
  assign core_pin_b_in = s_q.pb;
  assign core_clk_en   = s_q.clk_en;
  assign asleep        = s_q.sleep;
endmodule // pcpd_top

/* tb/pcpd_sys.sv */
// Purpose: System logic driving the sleep pins
// Assumes: Requests come from the bench
// Notes: Pins change just after an edge
`timescale 1ns/1ps
module pcpd_sys (
  input wire logic mclk, want_a, want_b,
  output logic     pin_a = 1'b0, pin_b = 1'b0
);
  always @(posedge mclk) begin
    pin_a <= want_a;
    pin_b <= want_b;
  end
endmodule // pcpd_sys

/* tb/pcpd_top_assertions.sv */
// Purpose: Port checks for pcpd_top
// Assumes: Default parameters, pin A sleeps
// Notes: Bound at foot
`timescale 1ns/1ps
module pcpd_chk (
  input wire logic mclk, rst, sleep_request_pin_a, sleep_request_pin_b, asleep,
  input wire logic core_pin_a_in, core_pin_b_in, core_clk_en,
  input wire logic [7:0] core_in, core_out, core_oe, pin_out, pin_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence req_on; sleep_request_pin_a [*4]; endsequence
  sequence req_off; !sleep_request_pin_a [*4]; endsequence
  sleep_entry_a: assert property (req_on |-> asleep) else $error("no sleep");
  sleep_exit_a: assert property (req_off |-> !asleep) else $error("no wake");
  out_held_a: assert property (!core_clk_en && !$past(core_clk_en)
    |-> $stable({pin_out, pin_oe})) else $error("out moved");
  in_held_a: assert property (!core_clk_en && !$past(core_clk_en)
    |-> $stable(core_in)) else $error("in moved");
  clk_gated_a: assert property (asleep |-> !core_clk_en) else $error("clock on");
  wake_bound_a: assert property ($fell(asleep) |-> ##[1:99] core_clk_en)
    else $error("slow wake");
  pin_hidden_a: assert property (!core_pin_a_in) else $error("pin seen");
  pin_b_used_a: assert property ((sleep_request_pin_b && core_clk_en) [*5]
    |-> core_pin_b_in) else $error("pin b lost");
  out_follow_a: assert property (core_clk_en [*2]
    |-> {pin_out, pin_oe} == $past({core_out, core_oe})) else $error("out lag");
endmodule // pcpd_chk
bind pcpd_top pcpd_chk u_chk (.*);

/* tb/pin_controlled_power_down_bench.sv */
// Purpose: Self-checking bench for pcpd_top
// Assumes: Default parameters, pin A sleeps
// Notes: One task per scenario
`timescale 1ns/1ps
module pin_controlled_power_down_bench;
  logic mclk = 1'b0, rst = 1'b1, want_a = 1'b0, want_b = 1'b0, pa, pb, slp, cpa, cpb, cen;
  logic [7:0] pin_in = 8'h3C, core_out = 8'hA5, core_oe = 8'h0F, core_in, pin_out, pin_oe;
  int fails = 0, n_tests = 0, cyc = 0, k;
  always #5 mclk = ~mclk;
  pcpd_sys u_sys (.mclk(mclk), .want_a(want_a), .want_b(want_b), .pin_a(pa), .pin_b(pb));
  pcpd_top DUT (.mclk(mclk), .rst(rst), .sleep_request_pin_a(pa), .sleep_request_pin_b(pb),
    .pin_in(pin_in), .core_in(core_in), .core_pin_a_in(cpa), .core_pin_b_in(cpb),
    .core_clk_en(cen), .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .asleep(slp));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task t_sleep;
    chk({pin_out, pin_oe, core_in, cen}, {8'hA5, 8'h0F, 8'h3C, 1'b1});
    @(posedge mclk) want_a <= 1'b1;
    for (k = 0; k < 9 && slp !== 1'b1; k++) @(negedge mclk);
    @(posedge mclk) {core_out, core_oe, pin_in} <= 24'h5AF0C3;
    repeat (20) @(negedge mclk);
    chk({pin_out, pin_oe, core_in, slp, cen, cpa}, {24'hA50F3C, 3'h4});
    @(posedge mclk) want_a <= 1'b0;
    for (k = 0; k < 200 && cen !== 1'b1; k++) @(negedge mclk);
    chk(32'(k <= 100), 32'h1);
    repeat (3) @(negedge mclk);
    chk({pin_out, pin_oe, core_in}, 32'h5AF0C3);
    $display("test sleep done");
  endtask
  task t_pin_b;
    @(posedge mclk) want_b <= 1'b1;
    repeat (20) @(negedge mclk);
    chk({slp, cpb}, 32'h1);
    @(posedge mclk) want_b <= 1'b0;
    $display("test pin b done");
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(negedge mclk);
    t_sleep;
    t_pin_b;
    end_of_test;
  end
endmodule // pin_controlled_power_down_bench
